//--- ctm_compare.sv
// Comparators A and P and the PWM duty compare
`timescale 1ns/100ps
module ctm_compare (
  input wire logic [9:0] cnt,
  input wire logic [9:0] cmp_a,
  input wire logic [2:0] per,
  input wire logic dpx,
  output logic a_hit,
  output logic p_hit,
  output logic duty_on
);

  logic [10:0] nxt;
  logic [10:0] p_len;
  logic [10:0] a_len;
  logic [10:0] duty;

  // ************************************************
  // Match detection on the next count value
  // ************************************************
  assign nxt = {1'b0, cnt} + 11'h001;
  // Period code 0 matches only at overflow
  assign p_len = {(per == 3'h0), per, ctm_pkg::CTM_P_LOW_ZERO};
  assign p_hit = (nxt == p_len);
  // A value 0 never matches
  assign a_hit = (cmp_a != 10'h000) && (nxt == {1'b0, cmp_a});
  assign a_len = (cmp_a == 10'h000) ? 11'h400 : {1'b0, cmp_a};

  // Duty source follows the swap bit
  assign duty = dpx ? p_len : a_len;
  // Duty at or above period keeps it on all period
  assign duty_on = ({1'b0, cnt} < duty);

endmodule // ctm_compare

//--- ctm_pin_load.sv
// External load on the timer pin: pull-down and pulse width meter
`timescale 1ns/100ps
module ctm_pin_load (
  input wire logic clk,
  input wire logic tp_out,
  input wire logic tp_oe,
  output logic pin,
  output int hi_len,
  output int lo_len
);
  logic last_reg = 1'b0;
  int run_reg = 0;
  // Line pulled low while the pin is released
  assign pin = tp_oe ? tp_out : 1'b0;
  // Length of the last whole high and low phase, in clocks
  always_ff @(posedge clk) begin
    last_reg <= pin;
    run_reg <= (pin !== last_reg) ? 1 : run_reg + 1;
    if (pin !== last_reg && last_reg) begin
      hi_len <= run_reg;
    end else if (pin !== last_reg) begin
      lo_len <= run_reg;
    end
  end
endmodule  // ctm_pin_load

//--- ctm_pkg.sv
// Package: constants and types of the compact timer
package ctm_pkg;

  // ************************************************
  // Register word indices on the bus
  // ************************************************
  localparam logic [2:0] CTM_IDX_CTRL0 = 3'h0;
  localparam logic [2:0] CTM_IDX_CTRL1 = 3'h1;
  localparam logic [2:0] CTM_IDX_CMPA = 3'h2;
  localparam logic [2:0] CTM_IDX_COUNT = 3'h3;
  localparam logic [2:0] CTM_IDX_FLAGS = 3'h4;

  // ************************************************
  // Field positions
  // ************************************************
  localparam int CTM_C0_PER_LSB = 0;
  localparam int CTM_C0_EN_BIT = 3;
  localparam int CTM_C0_DIV_LSB = 8;
  localparam int CTM_C1_CCLR_BIT = 0;
  localparam int CTM_C1_DPX_BIT = 1;
  localparam int CTM_C1_POL_BIT = 2;
  localparam int CTM_C1_OC_BIT = 3;
  localparam int CTM_C1_FUNC_LSB = 4;
  localparam int CTM_C1_MODE_LSB = 6;
  localparam int CTM_FL_A_BIT = 0;
  localparam int CTM_FL_P_BIT = 1;
  localparam int CTM_FL_PIN_BIT = 2;

  // ************************************************
  // Widths and reset values
  // ************************************************
  localparam int CTM_CNT_W = 10;
  localparam int CTM_PER_W = 3;
  localparam int CTM_DIV_W = 8;
  localparam logic [9:0] CTM_CNT_RST = 10'h000;
  localparam logic [9:0] CTM_CMPA_RST = 10'h000;
  localparam logic [7:0] CTM_CTRL_RST = 8'h00;
  localparam logic [7:0] CTM_DIV_RST = 8'h00;
  localparam logic [6:0] CTM_P_LOW_ZERO = 7'h00;

  // ************************************************
  // Operating modes and pin functions
  // ************************************************
  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'b00,
    CTM_MODE_RSV = 2'b01,
    CTM_MODE_PWM = 2'b10,
    CTM_MODE_TMR = 2'b11
  } ctm_mode_type;

  typedef enum logic [1:0] {
    CTM_FN_HOLD = 2'b00,
    CTM_FN_LOW = 2'b01,
    CTM_FN_HIGH = 2'b10,
    CTM_FN_TOGGLE = 2'b11
  } ctm_func_type;

endpackage

//--- ctm_tick_div.sv
// Timer clock divider: one-cycle tick every div+1 clocks
`timescale 1ns/100ps
module ctm_tick_div (
  input wire logic clk,
  input wire logic resetn,
  input wire logic restart,
  input wire logic [7:0] div,
  output logic tick
);

  logic [7:0] cnt_reg;

  // ************************************************
  // Prescale counter
  // ************************************************
  // Restart aligns the first tick with the enable edge
  always_ff @(posedge clk) begin
    if (!resetn || restart) begin
      cnt_reg <= ctm_pkg::CTM_DIV_RST;
    end else if (cnt_reg >= div) begin
      cnt_reg <= ctm_pkg::CTM_DIV_RST;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  assign tick = resetn && !restart && (cnt_reg >= div);

endmodule // ctm_tick_div

//--- ctm_timer.sv
// Compact 10-bit timer with compare, timer and PWM modes
`timescale 1ns/100ps

// Function
// - Mode bits: 00 compare output, 11 timer/counter, 10 PWM.
// - Compare, clear-select low: clear on P match or overflow; both flags.
// - Clear-select high: clear on A match; only A flag raised.
// - Clear-select high, A zero: overflow at 3FF, no A flag.
// - Compare mode: pin changes only on A flag, never on P.
// - On A match pin goes high, low or toggles; 00 no change.
// - Compare pin function: 00 hold, 01 low, 10 high, 11 toggle.
// - Compare mode: enable rising edge loads pin with initial level.
// - Output-control: initial level in compare, active level in PWM.
// - Timer mode counts like compare mode; pin unused.
// - PWM ignores clear-select; period register clear starts period.
// - Swap bit 0: P is period, A duty; 1 reversed.
// - Period code n gives 128*n timer ticks; code 0 gives 1024.
// - PWM duty at or above period gives 100% output.
// - PWM raises A flag on A match, P flag on P match.
// - PWM pin function enables waveform or forces fixed level.
// - PWM pin function: 00 inactive, 01 active, 10 waveform.
// - PWM counting and flags continue while pin is forced.
// - Polarity bit set inverts final pin output.
// - Timer mode ignores output-control and polarity bits.
module ctm_timer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic tp_out,
  output logic tp_oe
);

  // ************************************************
  // Declarations
  // ************************************************
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] div_reg;
  logic [9:0] cmpa_reg;
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  logic en_d_reg;
  logic flag_a_reg;
  logic flag_p_reg;
  logic lvl_reg;
  logic lvl_next;
  logic tp_out_reg;
  logic tp_out_next;
  logic tp_oe_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  logic enable;
  logic en_rise;
  logic [2:0] per;
  logic cclr;
  logic dpx;
  logic pol;
  logic oc;
  ctm_pkg::ctm_mode_type mode;
  ctm_pkg::ctm_func_type func;
  logic run;
  logic tick;
  logic step;
  logic a_hit;
  logic p_hit;
  logic duty_on;
  logic clr;
  logic a_evt;
  logic p_evt;
  logic pwm_wave;
  logic pwm_pin;
  logic bus_wr;
  logic bus_rd;
  logic take;
  logic clr_a;
  logic clr_p;

  // ************************************************
  // Field decoding
  // ************************************************
  assign enable = ctrl0_reg[ctm_pkg::CTM_C0_EN_BIT];
  assign per = ctrl0_reg[ctm_pkg::CTM_C0_PER_LSB +: ctm_pkg::CTM_PER_W];
  assign cclr = ctrl1_reg[ctm_pkg::CTM_C1_CCLR_BIT];
  assign dpx = ctrl1_reg[ctm_pkg::CTM_C1_DPX_BIT];
  assign pol = ctrl1_reg[ctm_pkg::CTM_C1_POL_BIT];
  assign oc = ctrl1_reg[ctm_pkg::CTM_C1_OC_BIT];
  // Mode select from the two mode bits
  assign mode = ctm_pkg::ctm_mode_type'(ctrl1_reg[ctm_pkg::CTM_C1_MODE_LSB +: 2]);
  assign func = ctm_pkg::ctm_func_type'(ctrl1_reg[ctm_pkg::CTM_C1_FUNC_LSB +: 2]);

  // ************************************************
  // Enable edge and run qualification
  // ************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= enable;
    end
  end

  assign en_rise = enable && !en_d_reg;
  // Reserved mode code holds the counter
  assign run = enable && (mode != ctm_pkg::CTM_MODE_RSV);

  // ************************************************
  // Timer clock enable
  // ************************************************
  ctm_tick_div u_div (
    .clk(clk),
    .resetn(resetn),
    .restart(en_rise),
    .div(div_reg),
    .tick(tick)
  );

  assign step = run && tick && !en_rise;

  // ************************************************
  // Comparators
  // ************************************************
  ctm_compare u_cmp (
    .cnt(cnt_reg),
    .cmp_a(cmpa_reg),
    .per(per),
    .dpx(dpx),
    .a_hit(a_hit),
    .p_hit(p_hit),
    .duty_on(duty_on)
  );

  // ************************************************
  // Clear source and match events
  // ************************************************
  always_comb begin
    clr = 1'b0;
    a_evt = 1'b0;
    p_evt = 1'b0;
    if (mode == ctm_pkg::CTM_MODE_PWM) begin
      // Period register clears; clear-select unused
      clr = dpx ? a_hit : p_hit;
      a_evt = a_hit;
      p_evt = p_hit;
    end else if (cclr) begin
      clr = a_hit;
      a_evt = a_hit;
      p_evt = 1'b0;
    end else begin
      clr = p_hit;
      a_evt = a_hit;
      p_evt = p_hit;
    end
  end

  // ************************************************
  // 10-bit count-up counter
  // ************************************************
  always_comb begin
    cnt_next = cnt_reg;
    if (en_rise) begin
      cnt_next = ctm_pkg::CTM_CNT_RST;
    end else if (step) begin
      if (clr) begin
        cnt_next = ctm_pkg::CTM_CNT_RST;
      end else begin
        cnt_next = cnt_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_reg <= ctm_pkg::CTM_CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // ************************************************
  // Match flags, set wins over software clear
  // ************************************************
  assign clr_a = take && bus_wr && (avs_address == ctm_pkg::CTM_IDX_FLAGS)
    && avs_writedata[ctm_pkg::CTM_FL_A_BIT];
  assign clr_p = take && bus_wr && (avs_address == ctm_pkg::CTM_IDX_FLAGS)
    && avs_writedata[ctm_pkg::CTM_FL_P_BIT];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      flag_a_reg <= 1'b0;
    end else if (step && a_evt) begin
      flag_a_reg <= 1'b1;
    end else if (clr_a) begin
      flag_a_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      flag_p_reg <= 1'b0;
    end else if (step && p_evt) begin
      flag_p_reg <= 1'b1;
    end else if (clr_p) begin
      flag_p_reg <= 1'b0;
    end
  end

  // ************************************************
  // Compare mode pin level
  // ************************************************
  always_comb begin
    lvl_next = lvl_reg;
    if (en_rise) begin
      lvl_next = oc;
    end else if (step && a_evt && (mode == ctm_pkg::CTM_MODE_CMP)) begin
      // Only A flag events move the pin
      case (func)
        ctm_pkg::CTM_FN_LOW: lvl_next = 1'b0;
        ctm_pkg::CTM_FN_HIGH: lvl_next = 1'b1;
        ctm_pkg::CTM_FN_TOGGLE: lvl_next = !lvl_reg;
        default: lvl_next = lvl_reg;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      lvl_reg <= 1'b0;
    end else begin
      lvl_reg <= lvl_next;
    end
  end

  // ************************************************
  // PWM waveform and pin forcing
  // ************************************************
  // Active level chosen by output-control
  assign pwm_wave = duty_on ? oc : !oc;

  always_comb begin
    case (func)
      ctm_pkg::CTM_FN_LOW: pwm_pin = oc;
      ctm_pkg::CTM_FN_HIGH: pwm_pin = pwm_wave;
      default: pwm_pin = !oc;
    endcase
  end

  // ************************************************
  // Output pin register
  // ************************************************
  always_comb begin
    tp_out_next = 1'b0;
    case (mode)
      ctm_pkg::CTM_MODE_CMP: tp_out_next = lvl_reg ^ pol;
      ctm_pkg::CTM_MODE_PWM: tp_out_next = pwm_pin ^ pol;
      default: tp_out_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tp_out_reg <= 1'b0;
      tp_oe_reg <= 1'b0;
    end else begin
      tp_out_reg <= tp_out_next;
      // Pin released in timer mode
      tp_oe_reg <= (mode == ctm_pkg::CTM_MODE_CMP) ||
        (mode == ctm_pkg::CTM_MODE_PWM);
    end
  end

  assign tp_out = tp_out_reg;
  assign tp_oe = tp_oe_reg;

  // ************************************************
  // Avalon-MM slave: one wait state per access
  // ************************************************
  assign bus_wr = avs_write && !avs_read;
  assign bus_rd = avs_read && !avs_write;
  // Request completes on the edge with waitrequest low
  assign take = (bus_wr || bus_rd) && !wait_reg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wait_reg <= 1'b1;
    end else if ((bus_wr || bus_rd) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // Register writes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl0_reg <= ctm_pkg::CTM_CTRL_RST;
      div_reg <= ctm_pkg::CTM_DIV_RST;
      ctrl1_reg <= ctm_pkg::CTM_CTRL_RST;
      cmpa_reg <= ctm_pkg::CTM_CMPA_RST;
    end else if (take && bus_wr) begin
      if (avs_address == ctm_pkg::CTM_IDX_CTRL0) begin
        ctrl0_reg <= avs_writedata[7:0];
        div_reg <= avs_writedata[ctm_pkg::CTM_C0_DIV_LSB +: ctm_pkg::CTM_DIV_W];
      end else if (avs_address == ctm_pkg::CTM_IDX_CTRL1) begin
        ctrl1_reg <= avs_writedata[7:0];
      end else if (avs_address == ctm_pkg::CTM_IDX_CMPA) begin
        cmpa_reg <= avs_writedata[ctm_pkg::CTM_CNT_W-1:0];
      end
    end
  end

  // Read data mux, unmapped reads as zero
  always_comb begin
    rdata_next = 32'h00000000;
    if (avs_address == ctm_pkg::CTM_IDX_CTRL0) begin
      rdata_next[31:16] = 16'h0000;
      rdata_next[7:4] = 4'h0;
      rdata_next[3:0] = ctrl0_reg[3:0];
      rdata_next[15:8] = div_reg;
    end else if (avs_address == ctm_pkg::CTM_IDX_CTRL1) begin
      rdata_next[7:0] = ctrl1_reg;
    end else if (avs_address == ctm_pkg::CTM_IDX_CMPA) begin
      rdata_next[9:0] = cmpa_reg;
    end else if (avs_address == ctm_pkg::CTM_IDX_COUNT) begin
      rdata_next[9:0] = cnt_reg;
    end else if (avs_address == ctm_pkg::CTM_IDX_FLAGS) begin
      rdata_next[ctm_pkg::CTM_FL_A_BIT] = flag_a_reg;
      rdata_next[ctm_pkg::CTM_FL_P_BIT] = flag_p_reg;
      rdata_next[ctm_pkg::CTM_FL_PIN_BIT] = tp_out_reg;
    end
  end

  // Read data captured while waitrequest is high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_reg <= 32'h00000000;
    end else if (bus_rd && wait_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;

endmodule // ctm_timer

//--- ctm_timer_props.sv
// Checker of the compact timer's bus handshake and pin levels
`timescale 1ns/100ps
module ctm_timer_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic tp_out,
  input wire logic tp_oe
);
  // ****
  // Shadow of written control fields
  // ****
  logic [7:0] c1_reg;
  logic [2:0] per_reg;
  logic [9:0] cmpa_reg;
  logic [1:0] quiet_reg;
  wire logic take = avs_write && !avs_waitrequest;
  wire logic [1:0] md = c1_reg[7:6];
  wire logic [1:0] fn = c1_reg[5:4];
  wire logic full = {1'b0, cmpa_reg} >= {per_reg == 3'h0, per_reg, 7'h00};
  // Capture each accepted write to words 0 to 2
  always_ff @(posedge clk) begin
    if (!resetn) begin
      c1_reg <= 8'h00;
      per_reg <= 3'h0;
      cmpa_reg <= 10'h000;
    end else if (take && avs_address == 3'h0) begin
      per_reg <= avs_writedata[2:0];
    end else if (take && avs_address == 3'h1) begin
      c1_reg <= avs_writedata[7:0];
    end else if (take && avs_address == 3'h2) begin
      cmpa_reg <= avs_writedata[9:0];
    end
  end
  // Cycles since the last write, saturating at three
  always_ff @(posedge clk) begin
    if (!resetn || take) begin
      quiet_reg <= 2'h0;
    end else if (quiet_reg != 2'h3) begin
      quiet_reg <= quiet_reg + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_wait_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than a cycle");
  a_wait_answer: assert property ((avs_read ^ avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 3'h4
    |-> avs_readdata == 32'h0) else $error("unmapped word reads nonzero");
  a_pin_enabled: assert property (quiet_reg == 2'h3 && !md[0] |=> tp_oe)
    else $error("pin not driven");
  a_timer_pin_free: assert property (quiet_reg == 2'h3 && md == 2'h3 |=> !tp_oe)
    else $error("pin driven in timer mode");
  a_cmp_hold_pin: assert property (quiet_reg == 2'h3 && md == 2'h0 && fn == 2'h0
    |=> $stable(tp_out)) else $error("pin moved without function");
  a_pwm_forced_level: assert property (quiet_reg == 2'h3 && md == 2'h2 && fn != 2'h2
    |=> tp_out == ((fn == 2'h1 ? c1_reg[3] : !c1_reg[3]) ^ c1_reg[2]))
    else $error("forced pwm level wrong");
  a_pwm_full_duty: assert property (quiet_reg == 2'h3 && md == 2'h2 && fn == 2'h2
    && !c1_reg[1] && full |=> tp_out == (c1_reg[3] ^ c1_reg[2]))
    else $error("full duty not held");
endmodule  // ctm_timer_chk

bind ctm_timer ctm_timer_chk u_chk (
  .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .tp_out(tp_out), .tp_oe(tp_oe)
);

//--- test_compact_timer_operating_modes.sv
// Self-checking bench of the compact timer modes
`timescale 1ns/100ps
module test_compact_timer_operating_modes;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic tp_out;
  logic tp_oe;
  logic pin;
  int hi_len;
  int lo_len;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int plen;
  int duty;
  logic [31:0] q;
  logic [31:0] r;
  logic [9:0] a;
  logic [7:0] dv;

  ctm_timer dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tp_out(tp_out), .tp_oe(tp_oe));
  ctm_pin_load load (.clk(clk), .tp_out(tp_out), .tp_oe(tp_oe), .pin(pin),
    .hi_len(hi_len), .lo_len(lo_len));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Cut a hung run short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      $display("wrong value at %0t: run timed out", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask

  // One bus transfer; read data lands in q
  task automatic bus(input logic we, input logic [2:0] adr, input logic [31:0] d);
    avs_address <= adr;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  // Stop, load control and compare, clear flags, restart
  task automatic cfg(input logic [7:0] c1, input logic [2:0] per, input logic [9:0] ca);
    bus(1'b1, 3'h0, 32'h0);
    bus(1'b1, 3'h1, {24'h0, c1});
    bus(1'b1, 3'h2, {22'h0, ca});
    bus(1'b1, 3'h4, 32'h3);
    bus(1'b1, 3'h0, {28'h0, 1'b1, per});
  endtask

  function automatic int per_len(input int p);
    return (p == 0) ? 1024 : 128 * p;
  endfunction

  function automatic logic cmp_pin(input logic [1:0] fn, input logic oc);
    return (fn == 2'h0) ? oc : (fn == 2'h1) ? 1'b0 : (fn == 2'h2) ? 1'b1 : !oc;
  endfunction

  initial begin
    void'($urandom(89));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // Reset values; unmapped words ignore writes and read zero
    bus(1'b1, 3'h6, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, i[2:0], 32'h0);
      chk(q, 32'h0);
    end
    r = $urandom;
    bus(1'b1, 3'h1, r);
    bus(1'b0, 3'h1, 32'h0);
    chk(q, {24'h0, r[7:0]});
    // Compare mode, period clear: toggle once per period
    for (int p = 0; p < 8; p++) begin
      cfg(8'h30, p[2:0], 10'h005);
      repeat (3 * per_len(p) + 20) @(posedge clk);
      chk(hi_len, per_len(p));
      bus(1'b0, 3'h4, 32'h0);
      chk(q & 32'h3, 32'h3);
    end
    // Clear on A match above the period value
    a = 10'(129 + $urandom % 800);
    cfg(8'h31, 3'h1, a);
    repeat (3 * a + 20) @(posedge clk);
    chk(hi_len, a);
    bus(1'b0, 3'h4, 32'h0);
    chk(q & 32'h3, 32'h1);
    // A value zero: overflow, no flag, no pin change
    cfg(8'h31, 3'h1, 10'h000);
    repeat (1100) @(posedge clk);
    bus(1'b0, 3'h4, 32'h0);
    chk(q, 32'h0);
    // Every pin function, initial level and polarity
    for (int k = 0; k < 16; k++) begin
      cfg({2'b00, k[3:0], 2'b01}, 3'h1, 10'h014);
      repeat (6) @(posedge clk);
      chk(pin, k[1] ^ k[0]);
      repeat (24) @(posedge clk);
      chk(pin, cmp_pin(k[3:2], k[1]) ^ k[0]);
    end
    // Prescaled timer clock stretches the period
    dv = 8'(1 + $urandom % 4);
    cfg(8'h30, 3'h1, 10'h005);
    bus(1'b1, 3'h0, 32'h0);
    bus(1'b1, 3'h0, {16'h0, dv, 8'h09});
    repeat (384 * (dv + 1) + 20) @(posedge clk);
    chk(hi_len, 128 * (dv + 1));
    // Timer mode: flags run, pin released
    cfg(8'hFC, 3'h1, 10'h005);
    // Enable edge zeroed the count; three ticks pass per read
    bus(1'b0, 3'h3, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 3'h3, 32'h0);
    chk(q, 32'h3);
    repeat (300) @(posedge clk);
    bus(1'b0, 3'h4, 32'h0);
    chk({q[1:0], tp_oe, pin}, 32'hC);
    // PWM, both swap settings and polarities
    for (int s = 0; s < 4; s++) begin
      a = s[0] ? 10'(300 + $urandom % 700) : 10'(1 + $urandom % 250);
      plen = s[0] ? a : 256;
      duty = s[0] ? 256 : a;
      cfg({4'hA, 1'b1, s[1], s[0], 1'($urandom)}, 3'h2, a);
      repeat (3 * plen + 20) @(posedge clk);
      chk(s[1] ? lo_len : hi_len, duty);
      chk(hi_len + lo_len, plen);
      bus(1'b0, 3'h4, 32'h0);
      chk(q & 32'h3, 32'h3);
      for (int f = 0; f < 2; f++) begin
        cfg({2'b10, 1'b0, f[0], 1'b1, s[1], s[0], 1'b0}, 3'h2, a);
        repeat (plen + 20) @(posedge clk);
        bus(1'b0, 3'h4, 32'h0);
        chk({q[1:0], pin}, {2'h3, f[0] ^ s[1]});
      end
    end
    // Duty equal to period gives full output
    cfg(8'hA8, 3'h2, 10'h100);
    repeat (600) @(posedge clk);
    chk(pin, 1'b1);
    stop_test();
  end
endmodule  // test_compact_timer_operating_modes
